//--- include/angle_port_regs.svh
// constants of the angle encoder serial and pulse-width port
`ifndef ANGLE_PORT_REGS_SVH
`define ANGLE_PORT_REGS_SVH

// command codes
`define CMD_RD_ANGLE    5'h00
`define CMD_RD_TURNS    5'h01
`define CMD_RD_SINE     5'h02
`define CMD_STORE_REF   5'h03
`define CMD_RD_BOTH     5'h04
`define CMD_RD_COSINE   5'h06
`define CMD_RD_THR_GAIN 5'h07
`define CMD_WR_SLEEP    5'h11
`define CMD_WR_SINE     5'h12
`define CMD_WR_HYST_RST 5'h13
`define CMD_WR_TEST     5'h15
`define CMD_WR_COSINE   5'h16
`define CMD_WR_THR_GAIN 5'h17

// frame geometry
`define CMD_BITS        5'h05
`define FRAME_BITS      5'h15

// field positions in the data word
`define F_LOCK          15
`define F_SLEEP_REQ     15
`define F_NV_RELOAD     15
`define F_TURN_CLR      13
`define F_HYST_EN       11
`define F_DIG_RST       14
`define F_STORE_OK      15
`define F_VDD_OK        14
`define F_REG_SET       13

// reset values
`define RST_HALL        16'h0000
`define RST_WAKE_THR    7'h04
`define MIN_WAKE_THR    7'h04
`define RST_GAIN        3'h0
`define RST_HYST_EN     1'b1

// pulse-width timing
`define CLK_SYS_MHZ     40
`define PWM_STEP_NS     556
`define PWM_STEP_CYC    ((`PWM_STEP_NS * `CLK_SYS_MHZ) / 1000)
`define PWM_LAST_POS    9'h100

`endif

//--- include/angle_port_pkg.sv
// types of the angle encoder serial and pulse-width port
package angle_port_pkg;

  typedef struct packed {
    logic        lock;
    logic [5:0]  agc;
    logic [7:0]  angle;
    logic        result_stb;
    logic        turn_up;
    logic        turn_dn;
    logic        store_ok;
    logic        vdd_ok;
  } sens_t;

  typedef struct packed {
    logic [15:0] hall_cos;
    logic [15:0] hall_sin;
    logic [6:0]  wake_thresh;
    logic [2:0]  gain;
    logic        sleep;
    logic        hyst_en;
  } cfg_t;

  typedef enum logic [2:0] {
    SER_IDLE,
    SER_CMD,
    SER_RDATA,
    SER_WDATA,
    SER_SKIP
  } ser_st_t;

  typedef struct packed {
    logic        sel_s1;
    logic        sel_s2;
    logic        clk_s1;
    logic        clk_s2;
    logic        clk_prev;
    logic        din_s1;
    logic        din_s2;
    ser_st_t     st;
    logic [4:0]  cnt;
    logic [4:0]  cmd;
    logic [15:0] sh;
    logic        oe;
    cfg_t        cfg;
    logic [7:0]  angle;
    logic [7:0]  cand;
    logic [7:0]  turns;
    logic [7:0]  ref_angle;
    logic        reg_set;
    logic        nv_pulse;
    logic        rst_pulse;
  } port_state_t;

  typedef struct packed {
    logic [15:0] pre;
    logic [8:0]  pos;
    logic [7:0]  duty;
    logic        pwm;
  } pwm_state_t;

endpackage

//--- core/angle_pwm_gen.sv
// pulse-width angle output generator
`timescale 1ns/10ps
`default_nettype none
`include "angle_port_regs.svh"

module angle_pwm_gen #(
  parameter int STEP_CYC = `PWM_STEP_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_angle,
  input  wire logic       i_valid,
  output logic            o_pwm
);
  import angle_port_pkg::*;

  localparam logic [15:0] STEP_LAST = 16'(STEP_CYC - 1);

  pwm_state_t q;
  pwm_state_t d;

  always_comb begin
    d = q;
    if (!i_rst_n) begin
      d = '0;
    end else begin
      if (q.pre == STEP_LAST) begin
        d.pre = '0;
        if (q.pos == `PWM_LAST_POS) begin
          d.pos  = '0;
          d.duty = i_angle;
        end else begin
          d.pos = q.pos + 9'h001;
        end
      end else begin
        d.pre = q.pre + 16'h0001;
      end
      d.pwm = i_valid && (d.pos <= {1'b0, d.duty}); // R3 R4
    end
  end

  always_ff @(posedge i_clk_sys) begin
    q <= d;
  end

  assign o_pwm = q.pwm;

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_pwm_low_invalid: assert property (!i_valid |=> !q.pwm) // R4
    else $error("pwm not low while angle invalid");
  a_pwm_period_len: assert property (q.pos <= `PWM_LAST_POS) // R3
    else $error("pwm step position beyond period");
  a_pwm_last_step: assert property (q.pos == `PWM_LAST_POS |-> !q.pwm) // R3
    else $error("pwm high in final step of period");

endmodule
`default_nettype wire

//--- core/angle_serial_port.sv
// three-wire serial command port and pulse-width output of the angle encoder
`timescale 1ns/10ps
`default_nettype none
`include "angle_port_regs.svh"

// Overview of operation
// R1 - all commands and data pass on one data line, framed by select, host clocked
// R2 - each frame is a 5-bit command msb first then 16 data bits, 15 down to 0
// R3 - pwm high for angle+1 steps of 0.556 us within a 257-step period
// R4 - pwm held low while the angle is invalid
// R5 - angle read returns lock, 6-bit gain level, angle and even parity
// R6 - turn read returns lock, gain level, turn count and even parity
// R7 - combined read returns turn count high byte and angle low byte, no parity
// R8 - store command latches angle and returns supply flags, written flag, angle, parity
// R9 - sleep write bit 15 enters low power, zero returns to normal
// R10 - in low power the lock flag reads zero in angle and turn reads
// R11 - threshold/gain write loads 7-bit threshold and 3-bit gain, read returns both
// R12 - wake threshold resets to 4, never below 4, at most 127
// R13 - with hysteresis on, angle changes only after two equal new results
// R14 - turn-counter clear bit zeroes the multi-turn counter
// R15 - host sets reload bit after start-up and each wake pulse
// R16 - digital-reset bit of test command resets the digital logic
// R17 - cosine and sine writes hold disable and invert bits for eight elements
// R18 - cosine and sine reads return the array words, reset to zero
// R19 - host reloads or starts with storage supply low before extended access
// R20 - host holds select high to frame each transfer
// R21 - command bits sampled on the rising serial clock edge
// R22 - device drives data only after the rising edge of the last command bit
// R23 - reserved command codes change nothing and leave the data line undriven
module angle_serial_port #(
  parameter int PWM_STEP_CYC = `PWM_STEP_CYC
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_select,
  input  wire logic                  i_serial_clock_input,
  input  wire logic                  i_serial_data_line,
  output logic                       o_serial_data_line,
  output logic                       o_serial_data_line_oe,
  input  wire angle_port_pkg::sens_t i_sens,
  output angle_port_pkg::cfg_t       o_cfg,
  output logic [7:0]                 o_turns,
  output logic                       o_nv_reload,
  output logic                       o_digital_reset,
  output logic                       o_pwm
);
  import angle_port_pkg::*;

  localparam cfg_t CFG_RST = '{
    hall_cos:    `RST_HALL,
    hall_sin:    `RST_HALL,
    wake_thresh: `RST_WAKE_THR,
    gain:        `RST_GAIN,
    sleep:       1'b0,
    hyst_en:     `RST_HYST_EN
  };

  port_state_t q;
  port_state_t d;
  logic        rise;
  logic        fall;
  logic [4:0]  cmd_w;
  logic [15:0] word_w;
  logic        lock_eff;

  function automatic logic [15:0] with_parity(input logic [15:0] w);
    with_parity = {w[15:1], ^w[15:1]};
  endfunction

  function automatic logic is_read(input logic [4:0] c);
    is_read = (c == `CMD_RD_ANGLE) || (c == `CMD_RD_TURNS) || (c == `CMD_RD_SINE)
           || (c == `CMD_STORE_REF) || (c == `CMD_RD_BOTH) || (c == `CMD_RD_COSINE)
           || (c == `CMD_RD_THR_GAIN);
  endfunction

  function automatic logic is_write(input logic [4:0] c);
    is_write = (c == `CMD_WR_SLEEP) || (c == `CMD_WR_SINE) || (c == `CMD_WR_HYST_RST)
            || (c == `CMD_WR_TEST) || (c == `CMD_WR_COSINE) || (c == `CMD_WR_THR_GAIN);
  endfunction

  assign rise     = q.clk_s2 & ~q.clk_prev;
  assign fall     = ~q.clk_s2 & q.clk_prev;
  assign cmd_w    = {q.cmd[3:0], q.din_s2};
  assign word_w   = {q.sh[14:0], q.din_s2};
  assign lock_eff = i_sens.lock & ~q.cfg.sleep; // R10

  always_comb begin
    d           = q;
    d.nv_pulse  = 1'b0;
    d.rst_pulse = 1'b0;
    // two-stage synchronisers on the pins
    d.sel_s1   = i_select;
    d.sel_s2   = q.sel_s1;
    d.clk_s1   = i_serial_clock_input;
    d.clk_s2   = q.clk_s1;
    d.clk_prev = q.clk_s2;
    d.din_s1   = i_serial_data_line;
    d.din_s2   = q.din_s1;

    // angle hysteresis
    if (i_sens.result_stb) begin
      d.cand = i_sens.angle;
      if (!q.cfg.hyst_en || (i_sens.angle == q.cand)) begin
        d.angle = i_sens.angle; // R13
      end
    end
    // multi-turn counter
    if (i_sens.turn_up && !i_sens.turn_dn) begin
      d.turns = q.turns + 8'h01;
    end else if (i_sens.turn_dn && !i_sens.turn_up) begin
      d.turns = q.turns - 8'h01;
    end

    // serial framing
    if (!q.sel_s2) begin // R20
      d.st  = SER_IDLE;
      d.cnt = '0;
      d.oe  = 1'b0;
    end else begin
      case (q.st)
        SER_IDLE: begin
          d.st  = SER_CMD;
          d.cnt = '0;
        end
        SER_CMD: begin
          if (rise) begin
            d.cmd = cmd_w; // R21 R2
            d.cnt = q.cnt + 5'h01;
            if (q.cnt + 5'h01 == `CMD_BITS) begin
              if (is_read(cmd_w)) begin
                d.st = SER_RDATA;
                d.oe = 1'b1; // R22 R1
                case (cmd_w)
                  `CMD_RD_ANGLE:
                    d.sh = with_parity({lock_eff, i_sens.agc, q.angle, 1'b0}); // R5
                  `CMD_RD_TURNS:
                    d.sh = with_parity({lock_eff, i_sens.agc, q.turns, 1'b0}); // R6
                  `CMD_RD_BOTH:
                    d.sh = {q.turns, q.angle}; // R7
                  `CMD_STORE_REF: begin
                    d.ref_angle = q.angle; // R8
                    d.reg_set   = 1'b1;
                    d.sh = with_parity({i_sens.store_ok, i_sens.vdd_ok, 1'b1,
                                        4'h0, q.angle, 1'b0}); // R8
                  end
                  `CMD_RD_THR_GAIN:
                    d.sh = with_parity({q.cfg.wake_thresh, q.cfg.gain,
                                        6'h00}); // R11
                  `CMD_RD_COSINE:
                    d.sh = q.cfg.hall_cos; // R18
                  `CMD_RD_SINE:
                    d.sh = q.cfg.hall_sin; // R18
                  default:
                    d.sh = '0;
                endcase
              end else if (is_write(cmd_w)) begin
                d.st = SER_WDATA;
              end else begin
                d.st = SER_SKIP; // R23
              end
            end
          end
        end
        SER_RDATA: begin
          if (rise) begin
            d.cnt = q.cnt + 5'h01;
          end
          if (fall && (q.cnt > `CMD_BITS)) begin
            d.sh = {q.sh[14:0], 1'b0}; // R2
          end
        end
        SER_WDATA: begin
          if (rise) begin
            d.sh  = word_w; // R2
            d.cnt = q.cnt + 5'h01;
            if (q.cnt + 5'h01 == `FRAME_BITS) begin
              d.st = SER_SKIP;
              case (q.cmd)
                `CMD_WR_THR_GAIN: begin
                  d.cfg.wake_thresh = (word_w[15:9] < `MIN_WAKE_THR) ?
                                      `MIN_WAKE_THR : word_w[15:9]; // R11 R12
                  d.cfg.gain = word_w[8:6]; // R11
                end
                `CMD_WR_COSINE:
                  d.cfg.hall_cos = word_w; // R17
                `CMD_WR_SINE:
                  d.cfg.hall_sin = word_w; // R17
                `CMD_WR_SLEEP:
                  d.cfg.sleep = word_w[`F_SLEEP_REQ]; // R9
                `CMD_WR_HYST_RST: begin
                  d.cfg.hyst_en = word_w[`F_HYST_EN]; // R13
                  d.nv_pulse    = word_w[`F_NV_RELOAD];
                  if (word_w[`F_TURN_CLR]) begin
                    d.turns = '0; // R14
                  end
                end
                `CMD_WR_TEST: begin
                  if (word_w[`F_DIG_RST]) begin
                    d.cfg       = CFG_RST; // R16
                    d.turns     = '0;
                    d.angle     = '0;
                    d.cand      = '0;
                    d.ref_angle = '0;
                    d.reg_set   = 1'b0;
                    d.rst_pulse = 1'b1;
                  end
                end
                default: begin
                end
              endcase
            end
          end
        end
        SER_SKIP: begin
          d.oe = 1'b0;
        end
        default: begin
          d.st = SER_IDLE;
        end
      endcase
    end

    if (!i_rst_n) begin
      d     = '0;
      d.cfg = CFG_RST; // R12 R18
    end
  end

  always_ff @(posedge i_clk_sys) begin
    q <= d;
  end

  assign o_serial_data_line    = q.sh[15];
  assign o_serial_data_line_oe = q.oe;
  assign o_cfg                 = q.cfg;
  assign o_turns               = q.turns;
  assign o_nv_reload           = q.nv_pulse;
  assign o_digital_reset       = q.rst_pulse;

  angle_pwm_gen #(
    .STEP_CYC (PWM_STEP_CYC)
  ) u_pwm (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_angle   (q.angle),
    .i_valid   (lock_eff),
    .o_pwm     (o_pwm)
  );

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_thr_floor: assert property (q.cfg.wake_thresh >= `MIN_WAKE_THR) // R12
    else $error("wake threshold below floor");
  a_oe_after_cmd: assert property (q.oe |-> (q.cnt >= `CMD_BITS) && (q.st == SER_RDATA)) // R22
    else $error("data line driven before command complete");
  a_skip_quiet: assert property (q.st == SER_SKIP |=> !q.oe) // R23
    else $error("data line driven for ignored command");
  a_frame_release: assert property (!q.sel_s2 |=> !q.oe) // R1
    else $error("data line driven outside select frame");
  a_sleep_lock: assert property ($rose(q.oe) && q.cfg.sleep
                                 && (q.cmd == `CMD_RD_ANGLE) |-> !q.sh[15]) // R10
    else $error("lock reported during low power");
  a_even_parity: assert property ($rose(q.oe) && (q.cmd == `CMD_RD_ANGLE
                                  || q.cmd == `CMD_RD_TURNS) |-> !(^q.sh)) // R5
    else $error("odd parity in read response");
  a_hyst_pair: assert property ($changed(q.angle) && $past(q.cfg.hyst_en)
                                && !q.rst_pulse |-> q.angle == $past(q.cand)) // R13
    else $error("angle changed without two equal results");
  a_shift_order: assert property ((q.st == SER_RDATA) && fall && (q.cnt > `CMD_BITS)
                                  && q.sel_s2 |=> q.sh == {$past(q.sh[14:0]), 1'b0}) // R2
    else $error("read data not shifted msb first");

endmodule
`default_nettype wire

//--- tb/angle_host.sv
// host model driving the three-wire serial port
`timescale 1ns/10ps
`default_nettype none
module angle_host (
  input  wire logic i_clk_sys,
  input  wire logic i_wire,
  output logic      o_select,
  output logic      o_sclk,
  output logic      o_data,
  output logic      o_data_oe
);
  initial begin
    o_select = 1'b0;
    o_sclk = 1'b0;
    o_data = 1'b0;
    o_data_oe = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // one frame; the serial clock stands still outside it
  task automatic xfer(input logic [4:0] c, input logic [15:0] w, output logic [15:0] r);
    logic [20:0] f;
    f = {c, w};
    r = 16'h0000;
    o_select = 1'b1;
    for (int i = 20; i >= 0; i--) begin
      o_data_oe = (i > 15) || c[4];
      o_data = f[i];
      wt(5);
      o_sclk = 1'b1;
      if (i < 16) r[i] = i_wire;
      wt(3);
      o_sclk = 1'b0;
    end
    o_data_oe = 1'b0;
    wt(2);
    o_select = 1'b0;
    wt(6);
  endtask
endmodule
`default_nettype wire

//--- tb/angle_encoder_serial_pwm_port_bench.sv
// self-checking bench of the angle encoder serial and pulse-width port
`timescale 1ns/10ps
`default_nettype none
`include "angle_port_regs.svh"
module angle_encoder_serial_pwm_port_bench;
  import angle_port_pkg::*;
  localparam int STEP = 4;
  logic        i_clk_sys, i_rst_n, sel, sclk, hd, hoe, dd, doe, wire_v;
  logic        nv, drst, pwm, saw_oe;
  logic        flt = 1'b0;
  logic [7:0]  turns, a, te;
  logic [15:0] r, w;
  logic [31:0] lfsr;
  logic [6:0]  thr [5] = '{7'h00, 7'h03, 7'h04, 7'h05, 7'h7F};
  logic [4:0]  bad_cmd [6] = '{5'h05, 5'h08, 5'h0F, 5'h10, 5'h14, 5'h1F};
  sens_t       sens;
  cfg_t        cfg, c0;
  int          bad_count, check_count;
  int          nv_n = 0;
  int          dr_n = 0;

  assign wire_v = doe ? dd : (hoe ? hd : flt);

  angle_serial_port #(.PWM_STEP_CYC(STEP)) i_angle_serial_port (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_select(sel),
    .i_serial_clock_input(sclk), .i_serial_data_line(wire_v),
    .o_serial_data_line(dd), .o_serial_data_line_oe(doe), .i_sens(sens),
    .o_cfg(cfg), .o_turns(turns), .o_nv_reload(nv), .o_digital_reset(drst),
    .o_pwm(pwm));

  angle_host i_angle_host (
    .i_clk_sys(i_clk_sys), .i_wire(wire_v), .o_select(sel), .o_sclk(sclk),
    .o_data(hd), .o_data_oe(hoe));

  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys) begin
    flt <= ~flt;
    nv_n <= nv_n + (nv === 1'b1);
    dr_n <= dr_n + (drst === 1'b1);
    if (doe === 1'b1) saw_oe <= 1'b1;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // word with even parity in bit 0
  function automatic logic [15:0] wp(input logic [14:0] v);
    return {v, ^v};
  endfunction

  task automatic tk(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tx(input logic [4:0] c, input logic [15:0] d);
    i_angle_host.xfer(c, d, r);
  endtask

  task automatic res(input logic [7:0] v);
    sens.angle = v;
    sens.result_stb = 1'b1;
    tk(1);
    sens.result_stb = 1'b0;
    tk(1);
  endtask

  task automatic wl(input logic v);
    int p;
    p = 0;
    while (pwm !== v) begin
      tk(1);
      p++;
      if (p > 2200) begin
        bad_count++;
        conclude();
      end
    end
  endtask

  task automatic pw(input logic [7:0] v);
    int h;
    h = 0;
    tk(4);
    wl(1'b0);
    wl(1'b1);
    repeat (257 * STEP) begin
      h += (pwm === 1'b1);
      tk(1);
    end
    chk("pwm high", 16'(h), 16'((v + 1) * STEP));
    chk("pwm period", {15'h0, pwm}, 16'h0001);
  endtask

  task automatic lowchk();
    int h;
    h = 0;
    tk(2);
    repeat (1100) begin
      h += (pwm === 1'b1);
      tk(1);
    end
    chk("pwm low", 16'(h), 16'h0000);
  endtask

  initial begin
    repeat (100000) @(posedge i_clk_sys);
    bad_count++;
    conclude();
  end

  initial begin
    i_rst_n = 1'b0;
    sens = '0;
    lfsr = 32'h4C7ABCEC;
    saw_oe = 1'b0;
    te = 8'h00;
    tk(3);
    i_rst_n = 1'b1;
    tk(2);
    chk("hyst rst", {15'h0, cfg.hyst_en}, 16'h0001);
    tx(`CMD_RD_COSINE, 16'h0000);
    chk("cos rst", r, `RST_HALL);
    tx(`CMD_RD_SINE, 16'h0000);
    chk("sin rst", r, `RST_HALL);
    tx(`CMD_RD_THR_GAIN, 16'h0000);
    chk("thr rst", r, wp({7'h04, 8'h00}));
    tx(`CMD_WR_HYST_RST, 16'h8800);
    chk("reload", 16'(nv_n), 16'h0001);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      w = 16'(rnd());
      tx(i[0] ? `CMD_WR_SINE : `CMD_WR_COSINE, w);
      tx(i[0] ? `CMD_RD_SINE : `CMD_RD_COSINE, 16'h0000);
      chk("hall rd", r, w);
      chk("hall cfg", i[0] ? cfg.hall_sin : cfg.hall_cos, w);
    end
    foreach (thr[i]) begin
      w = {thr[i], 3'(rnd()), 6'h00};
      tx(`CMD_WR_THR_GAIN, w);
      tx(`CMD_RD_THR_GAIN, 16'h0000);
      chk("thr gain", r, wp({(thr[i] < 7'h04) ? 7'h04 : thr[i], w[8:6], 5'h00}));
    end
    $display("config test done");
    sens.lock = 1'b1;
    for (int i = 0; i < 4; i++) begin
      a = 8'(rnd());
      sens.agc = 6'(rnd());
      sens.turn_up = i[0];
      sens.turn_dn = ~i[0];
      tk(1);
      sens.turn_up = 1'b0;
      sens.turn_dn = 1'b0;
      te = te + (i[0] ? 8'h01 : 8'hFF);
      res(a);
      res(a);
      tx(`CMD_RD_ANGLE, 16'h0000);
      chk("angle rd", r, wp({1'b1, sens.agc, a}));
      tx(`CMD_RD_TURNS, 16'h0000);
      chk("turns rd", r, wp({1'b1, sens.agc, te}));
      tx(`CMD_RD_BOTH, 16'h0000);
      chk("both rd", r, {te, a});
    end
    res(~a);
    tx(`CMD_RD_BOTH, 16'h0000);
    chk("hyst hold", r, {te, a});
    tx(`CMD_WR_HYST_RST, 16'h2000);
    te = 8'h00;
    res(a);
    tx(`CMD_RD_BOTH, 16'h0000);
    chk("hyst off", r, {te, a});
    chk("turns out", {8'h00, turns}, 16'h0000);
    $display("angle test done");
    tx(`CMD_WR_SLEEP, 16'h8000);
    chk("sleep", {15'h0, cfg.sleep}, 16'h0001);
    tx(`CMD_RD_ANGLE, 16'h0000);
    chk("sleep angle", r, wp({1'b0, sens.agc, a}));
    tx(`CMD_RD_TURNS, 16'h0000);
    chk("sleep turns", r, wp({1'b0, sens.agc, te}));
    lowchk();
    tx(`CMD_WR_SLEEP, 16'h0000);
    chk("wake", {15'h0, cfg.sleep}, 16'h0000);
    sens.lock = 1'b0;
    lowchk();
    sens.lock = 1'b1;
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 8'h00 : ((i == 1) ? 8'hFF : 8'(rnd()));
      res(a);
      pw(a);
    end
    $display("pwm test done");
    sens.store_ok = 1'b1;
    sens.vdd_ok = 1'b0;
    tx(`CMD_STORE_REF, 16'h0000);
    chk("store", r, wp({3'b101, 4'h0, a}));
    c0 = cfg;
    saw_oe = 1'b0;
    foreach (bad_cmd[i]) tx(bad_cmd[i], 16'(rnd()));
    chk("resv oe", {15'h0, saw_oe}, 16'h0000);
    chk("resv cfg", {15'h0, cfg === c0}, 16'h0001);
    tx(`CMD_WR_TEST, 16'h4000);
    chk("dig rst", 16'(dr_n), 16'h0001);
    tx(`CMD_RD_COSINE, 16'h0000);
    chk("dig rst cos", r, `RST_HALL);
    chk("dig rst thr", {9'h0, cfg.wake_thresh}, {9'h0, `RST_WAKE_THR});
    $display("misc test done");
    conclude();
  end
endmodule
`default_nettype wire
